// file: oag_consts.vh
// Constants shared by the operand address generator and its helpers.
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH

// Addressing modes presented by the decode stage.
`define MODE_REG        4'h0
`define MODE_WREG       4'h1
`define MODE_IND        4'h2
`define MODE_IDX_RF     4'h3
`define MODE_IDX_SHORT  4'h4
`define MODE_IDX_LONG   4'h5
`define MODE_DIRECT     4'h6
`define MODE_TABLE      4'h7
`define MODE_REL        4'h8
`define MODE_LIT        4'h9
`define MODE_PUSH       4'hA
`define MODE_POP        4'hB

// Instruction classes presented by the decode stage.
`define INS_GENERIC     4'h0
`define INS_REG_LOAD    4'h1
`define INS_PM_LOAD     4'h2
`define INS_EXT_LOAD    4'h3
`define INS_JUMP        4'h4
`define INS_CALL        4'h5
`define INS_BTB_FALSE   4'h6
`define INS_BTB_TRUE    4'h7
`define INS_DEC_BNZ     4'h8
`define INS_CIB_EQ      4'h9
`define INS_CIB_NE      4'hA
`define INS_SHORT_JR    4'hB
`define INS_PUSH        4'hC
`define INS_POP         4'hD

// Target address spaces.
`define SPACE_NONE      2'h0
`define SPACE_REG       2'h1
`define SPACE_PROG      2'h2
`define SPACE_EXT       2'h3

// Register file layout.
`define WREG_ESCAPE     4'hC
`define PROTECT_BASE    8'hC0
`define RP_FIRST_RESET  8'hC0
`define RP_SECOND_RESET 8'hC8
`define SP_LOW_RESET    8'hFF

`endif

// file: working_register_former.v
// Forms a full register file address from a 4-bit or escaped 8-bit working register reference.
`timescale 1ns/1ps
`default_nettype none

module working_register_former (
	input  wire [7:0] first_window_pointer,
	input  wire [7:0] second_window_pointer,
	input  wire [7:0] reg_field,
	input  wire       short_form,
	output wire [7:0] full_addr,
	output wire       is_working
);
	`include "oag_consts.vh"

	wire [7:0] window;

	// An 8-bit address in the 1100B nibble range behaves like its low nibble.
	assign is_working = short_form | (reg_field[7:4] == `WREG_ESCAPE);
	assign window     = reg_field[3] ? second_window_pointer : first_window_pointer;
	assign full_addr  = is_working ? {window[7:3], reg_field[2:0]} : reg_field;
endmodule

`default_nettype wire

// file: operand_address_generator.v
// Operand effective-address generation for the 8-bit core.
`timescale 1ns/1ps
`default_nettype none

module operand_address_generator (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        req,
	input  wire [3:0]  mode,
	input  wire [3:0]  ins_class,
	input  wire        field_short,
	input  wire        op_word,
	input  wire [7:0]  ins_byte,
	input  wire [7:0]  ins_offset,
	input  wire [15:0] ins_word,
	input  wire [15:0] pc_follow,
	input  wire        rp_first_wr,
	input  wire        rp_second_wr,
	input  wire        sp_low_wr,
	input  wire [7:0]  wr_data,
	input  wire [7:0]  rf_rdata,
	input  wire [7:0]  pm_rdata,
	output reg         busy,
	output reg         done,
	output reg         fault_mode,
	output reg         fault_range,
	output reg  [15:0] eff_addr,
	output reg  [1:0]  addr_space,
	output reg  [15:0] operand,
	output reg  [15:0] pc_target,
	output reg         pc_load,
	output reg         rf_rd,
	output reg  [7:0]  rf_addr,
	output reg         pm_rd,
	output reg  [15:0] pm_addr,
	output reg  [7:0]  first_window_pointer,
	output reg  [7:0]  second_window_pointer,
	output reg  [7:0]  stack_pointer_low
);
	`include "oag_consts.vh"

	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_RD1  = 5'b00010;
	localparam [4:0] ST_RD2  = 5'b00100;
	localparam [4:0] ST_RD3  = 5'b01000;
	localparam [4:0] ST_CALC = 5'b10000;

	reg  [4:0]  state;
	reg  [3:0]  cur_mode;
	reg  [3:0]  cur_ins;
	reg  [7:0]  cur_byte;
	reg  [7:0]  cur_offset;
	reg  [15:0] cur_word;
	reg         cur_pair;
	reg         use_pm;
	reg  [7:0]  data_hi;
	reg  [7:0]  data_lo;

	wire [7:0]  field_addr;
	wire        field_working;
	wire [7:0]  rdata;
	wire [15:0] fetched;
	wire [15:0] rel_target;
	wire [15:0] disp_ext;
	wire [7:0]  rf_index_sum;
	wire        legal;
	wire        mem_pair;
	wire [1:0]  ins_space;

	working_register_former former (
		.first_window_pointer  (first_window_pointer),
		.second_window_pointer (second_window_pointer),
		.reg_field             (ins_byte),
		.short_form            (field_short),
		.full_addr             (field_addr),
		.is_working            (field_working)
	);

	// Checks that the instruction class may use the requested mode.
	function mode_allowed;
		input [3:0] m;
		input [3:0] c;
		reg         branch;
		reg         stack;
		begin
			branch = (c == `INS_BTB_FALSE) | (c == `INS_BTB_TRUE) | (c == `INS_DEC_BNZ) |
				(c == `INS_CIB_EQ) | (c == `INS_CIB_NE) | (c == `INS_SHORT_JR);
			stack = (c == `INS_PUSH) | (c == `INS_POP);
			case (m)
				`MODE_REG, `MODE_WREG, `MODE_IND, `MODE_LIT: begin
					mode_allowed = !branch & !stack;
				end
				`MODE_IDX_RF: begin
					mode_allowed = (c == `INS_REG_LOAD);
				end
				`MODE_IDX_SHORT, `MODE_IDX_LONG: begin
					mode_allowed = (c == `INS_PM_LOAD) | (c == `INS_EXT_LOAD);
				end
				`MODE_DIRECT: begin
					mode_allowed = (c == `INS_JUMP) | (c == `INS_CALL) |
						(c == `INS_PM_LOAD) | (c == `INS_EXT_LOAD);
				end
				`MODE_TABLE: begin
					mode_allowed = (c == `INS_CALL);
				end
				`MODE_REL: begin
					mode_allowed = branch;
				end
				`MODE_PUSH: begin
					mode_allowed = (c == `INS_PUSH);
				end
				`MODE_POP: begin
					mode_allowed = (c == `INS_POP);
				end
				default: begin
					mode_allowed = 1'b0;
				end
			endcase
		end
	endfunction

	assign legal = mode_allowed(mode, ins_class);

	// Register targets take a single byte pointer; every memory target takes a pair.
	assign ins_space = (ins_class == `INS_PM_LOAD) ? `SPACE_PROG :
		(ins_class == `INS_EXT_LOAD) ? `SPACE_EXT :
		((ins_class == `INS_JUMP) | (ins_class == `INS_CALL)) ? `SPACE_PROG : `SPACE_REG;
	assign mem_pair = (ins_space != `SPACE_REG);

	assign rdata        = use_pm ? pm_rdata : rf_rdata;
	assign fetched      = {data_hi, data_lo};
	assign disp_ext     = {{8{cur_offset[7]}}, cur_offset};
	assign rel_target   = pc_follow + {{8{ins_byte[7]}}, ins_byte};
	assign rf_index_sum = cur_byte + data_lo;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			state                 <= ST_IDLE;
			cur_mode              <= `MODE_REG;
			cur_ins               <= `INS_GENERIC;
			cur_byte              <= 8'h00;
			cur_offset            <= 8'h00;
			cur_word              <= 16'h0000;
			cur_pair              <= 1'b0;
			use_pm                <= 1'b0;
			data_hi               <= 8'h00;
			data_lo               <= 8'h00;
			busy                  <= 1'b0;
			done                  <= 1'b0;
			fault_mode            <= 1'b0;
			fault_range           <= 1'b0;
			eff_addr              <= 16'h0000;
			addr_space            <= `SPACE_NONE;
			operand               <= 16'h0000;
			pc_target             <= 16'h0000;
			pc_load               <= 1'b0;
			rf_rd                 <= 1'b0;
			rf_addr               <= 8'h00;
			pm_rd                 <= 1'b0;
			pm_addr               <= 16'h0000;
			first_window_pointer  <= `RP_FIRST_RESET;
			second_window_pointer <= `RP_SECOND_RESET;
			stack_pointer_low     <= `SP_LOW_RESET;
		end else begin
			done    <= 1'b0;
			pc_load <= 1'b0;
			if (rp_first_wr) begin
				first_window_pointer <= wr_data;
			end
			if (rp_second_wr) begin
				second_window_pointer <= wr_data;
			end
			// A stack access in the same cycle overrides a software write of the pointer.
			if (sp_low_wr && !(state == ST_IDLE && req && legal &&
				(mode == `MODE_PUSH || mode == `MODE_POP))) begin
				stack_pointer_low <= wr_data;
			end
			case (state)
				ST_IDLE: begin
					if (req) begin
						cur_mode    <= mode;
						cur_ins     <= ins_class;
						cur_byte    <= ins_byte;
						cur_offset  <= ins_offset;
						cur_word    <= ins_word;
						fault_mode  <= !legal;
						fault_range <= 1'b0;
						operand     <= 16'h0000;
						data_hi     <= 8'h00;
						data_lo     <= 8'h00;
						busy        <= 1'b1;
						if (!legal) begin
							addr_space <= `SPACE_NONE;
							state      <= ST_CALC;
						end else begin
							case (mode)
								`MODE_REG, `MODE_WREG: begin
									// Pairs start on the even register, high byte first.
									cur_pair   <= op_word;
									use_pm     <= 1'b0;
									rf_rd      <= 1'b1;
									rf_addr    <= op_word ? {field_addr[7:1], 1'b0} : field_addr;
									eff_addr   <= {8'h00, field_addr};
									addr_space <= `SPACE_REG;
									state      <= ST_RD1;
								end
								`MODE_IND: begin
									cur_pair   <= mem_pair;
									use_pm     <= 1'b0;
									rf_rd      <= 1'b1;
									rf_addr    <= mem_pair ? {field_addr[7:1], 1'b0} : field_addr;
									addr_space <= ins_space;
									state      <= ST_RD1;
								end
								`MODE_IDX_RF: begin
									cur_pair   <= 1'b0;
									use_pm     <= 1'b0;
									rf_rd      <= 1'b1;
									rf_addr    <= field_addr;
									addr_space <= `SPACE_REG;
									state      <= ST_RD1;
								end
								`MODE_IDX_SHORT, `MODE_IDX_LONG: begin
									cur_pair   <= 1'b1;
									use_pm     <= 1'b0;
									rf_rd      <= 1'b1;
									rf_addr    <= {field_addr[7:1], 1'b0};
									addr_space <= ins_space;
									state      <= ST_RD1;
								end
								`MODE_TABLE: begin
									cur_pair   <= 1'b1;
									use_pm     <= 1'b1;
									pm_rd      <= 1'b1;
									pm_addr    <= {8'h00, ins_byte};
									addr_space <= `SPACE_PROG;
									state      <= ST_RD1;
								end
								`MODE_DIRECT: begin
									eff_addr   <= ins_word;
									addr_space <= ins_space;
									pc_target  <= ins_word;
									pc_load    <= (ins_class == `INS_JUMP) | (ins_class == `INS_CALL);
									state      <= ST_CALC;
								end
								`MODE_REL: begin
									pc_target  <= rel_target;
									pc_load    <= 1'b1;
									addr_space <= `SPACE_PROG;
									eff_addr   <= rel_target;
									state      <= ST_CALC;
								end
								`MODE_LIT: begin
									operand    <= op_word ? ins_word : {8'h00, ins_byte};
									addr_space <= `SPACE_NONE;
									state      <= ST_CALC;
								end
								`MODE_PUSH: begin
									stack_pointer_low <= stack_pointer_low - 8'h01;
									eff_addr          <= {8'h00, stack_pointer_low - 8'h01};
									addr_space        <= `SPACE_REG;
									state             <= ST_CALC;
								end
								`MODE_POP: begin
									stack_pointer_low <= stack_pointer_low + 8'h01;
									eff_addr          <= {8'h00, stack_pointer_low};
									addr_space        <= `SPACE_REG;
									state             <= ST_CALC;
								end
								default: begin
									fault_mode <= 1'b1;
									addr_space <= `SPACE_NONE;
									state      <= ST_CALC;
								end
							endcase
						end
					end
				end
				ST_RD1: begin
					// The second byte of a pair is requested while the first is in flight.
					if (cur_pair) begin
						rf_rd   <= !use_pm;
						pm_rd   <= use_pm;
						rf_addr <= {rf_addr[7:1], 1'b1};
						pm_addr <= pm_addr + 16'h0001;
					end else begin
						rf_rd <= 1'b0;
						pm_rd <= 1'b0;
					end
					state <= ST_RD2;
				end
				ST_RD2: begin
					rf_rd <= 1'b0;
					pm_rd <= 1'b0;
					if (cur_pair) begin
						data_hi <= rdata;
						state   <= ST_RD3;
					end else begin
						data_lo <= rdata;
						state   <= ST_CALC;
					end
				end
				ST_RD3: begin
					data_lo <= rdata;
					state   <= ST_CALC;
				end
				ST_CALC: begin
					case (cur_mode)
						`MODE_REG, `MODE_WREG: begin
							operand <= fetched;
						end
						`MODE_IND: begin
							if (addr_space == `SPACE_REG) begin
								eff_addr    <= {8'h00, data_lo};
								fault_range <= (data_lo >= `PROTECT_BASE);
							end else begin
								eff_addr  <= fetched;
								pc_target <= fetched;
								pc_load   <= (cur_ins == `INS_JUMP) | (cur_ins == `INS_CALL);
							end
						end
						`MODE_IDX_RF: begin
							eff_addr    <= {8'h00, rf_index_sum};
							fault_range <= (rf_index_sum >= `PROTECT_BASE);
						end
						`MODE_IDX_SHORT: begin
							eff_addr <= fetched + disp_ext;
						end
						`MODE_IDX_LONG: begin
							eff_addr <= fetched + cur_word;
						end
						`MODE_TABLE: begin
							eff_addr  <= fetched;
							pc_target <= fetched;
							pc_load   <= !fault_mode;
						end
						default: begin
							eff_addr <= eff_addr;
						end
					endcase
					done  <= 1'b1;
					busy  <= 1'b0;
					state <= ST_IDLE;
				end
				default: begin
					rf_rd <= 1'b0;
					pm_rd <= 1'b0;
					busy  <= 1'b0;
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

// file: oag_assertions.sv
// Concurrent checks on the ports of the operand address generator.
`timescale 1ns/1ps
`default_nettype none
`include "oag_consts.vh"
module oag_checker (
	input wire        clk_sys,
	input wire        rst_n,
	input wire        req,
	input wire [3:0]  mode,
	input wire [3:0]  ins_class,
	input wire        field_short,
	input wire        op_word,
	input wire [7:0]  ins_byte,
	input wire [15:0] ins_word,
	input wire [15:0] pc_follow,
	input wire        busy,
	input wire        done,
	input wire        fault_mode,
	input wire        fault_range,
	input wire [15:0] eff_addr,
	input wire [1:0]  addr_space,
	input wire [15:0] pc_target,
	input wire        pc_load,
	input wire        rf_rd,
	input wire [7:0]  rf_addr,
	input wire        pm_rd,
	input wire [15:0] pm_addr,
	input wire [7:0]  first_window_pointer,
	input wire [7:0]  second_window_pointer,
	input wire [7:0]  stack_pointer_low
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire take = req && !busy;
	wire branch = ins_class >= `INS_BTB_FALSE && ins_class <= `INS_SHORT_JR;
	wire plain = ins_class == `INS_GENERIC && !op_word;
	reg [3:0] last_mode;
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			last_mode <= `MODE_REG;
		end else if (take) begin
			last_mode <= mode;
		end
	end
	sequence s_refuse;
		##2 done && fault_mode;
	endsequence
	sequence s_table_fetch;
		pm_rd && pm_addr == {8'h00, $past(ins_byte)} ##1 pm_rd && pm_addr == {8'h00, $past(ins_byte, 2)} + 16'h0001;
	endsequence
	AST_BUSY_BOUND: assert property (take |=> busy ##[1:4] done)
		else $error("request not answered in time");
	AST_IDX_RF_CLASS: assert property (take && mode == `MODE_IDX_RF && ins_class != `INS_REG_LOAD |-> s_refuse)
		else $error("register indexed accepted for a non load");
	AST_TABLE_CLASS: assert property (take && mode == `MODE_TABLE && ins_class != `INS_CALL |-> s_refuse)
		else $error("table vector accepted for a non call");
	AST_REL_CLASS: assert property (take && mode == `MODE_REL && !branch |-> s_refuse)
		else $error("relative mode accepted for a non branch");
	AST_TABLE_FETCH: assert property (take && mode == `MODE_TABLE && ins_class == `INS_CALL |=> s_table_fetch)
		else $error("table pair fetch address wrong");
	AST_DIRECT_PC: assert property (take && mode == `MODE_DIRECT && ins_class == `INS_JUMP
		|=> pc_load && pc_target == $past(ins_word))
		else $error("direct jump target wrong");
	AST_REL_PC: assert property (take && mode == `MODE_REL && branch
		|=> pc_load && pc_target == $past(pc_follow) + {{8{$past(ins_byte[7])}}, $past(ins_byte)})
		else $error("relative target wrong");
	AST_WREG_ADDR: assert property (take && mode == `MODE_WREG && field_short && plain
		|=> rf_rd && rf_addr == {$past(ins_byte[3] ? second_window_pointer[7:3] : first_window_pointer[7:3]),
			$past(ins_byte[2:0])})
		else $error("working register address wrong");
	AST_ESCAPE: assert property (take && mode == `MODE_REG && !field_short && ins_byte[7:4] == 4'hC && plain
		|=> rf_rd && rf_addr == {$past(ins_byte[3] ? second_window_pointer[7:3] : first_window_pointer[7:3]),
			$past(ins_byte[2:0])})
		else $error("escaped working reference not decoded");
	AST_RANGE: assert property (done && addr_space == `SPACE_REG
		&& (last_mode == `MODE_IND || last_mode == `MODE_IDX_RF) |-> fault_range == (eff_addr[7:0] >= 8'hC0))
		else $error("protected range flag wrong");
	AST_PUSH: assert property (take && mode == `MODE_PUSH && ins_class == `INS_PUSH
		|=> stack_pointer_low == $past(stack_pointer_low) - 8'h01 && eff_addr[7:0] == stack_pointer_low)
		else $error("push did not predecrement");
	AST_POP: assert property (take && mode == `MODE_POP && ins_class == `INS_POP
		|=> stack_pointer_low == $past(stack_pointer_low) + 8'h01 && eff_addr[7:0] == $past(stack_pointer_low))
		else $error("pop did not postincrement");
endmodule
bind operand_address_generator oag_checker chk (.*);
`default_nettype wire

// file: memory_model.sv
// Register file and program memory answering the address generator's reads.
`timescale 1ns/1ps
`default_nettype none
module memory_model (
	input  wire        clk_sys,
	input  wire        rf_rd,
	input  wire [7:0]  rf_addr,
	input  wire        pm_rd,
	input  wire [15:0] pm_addr,
	output var logic [7:0] rf_rdata,
	output var logic [7:0] pm_rdata
);
	// Contents are a fixed function of the address so every byte is predictable.
	// Outside a read the buses toggle, so a capture on the wrong cycle cannot match by luck.
	initial begin
		rf_rdata = 8'h00;
		pm_rdata = 8'h00;
	end
	always @(posedge clk_sys) begin
		if (rf_rd) begin
			rf_rdata <= ~rf_addr;
		end else begin
			rf_rdata <= ~rf_rdata;
		end
		if (pm_rd) begin
			pm_rdata <= pm_addr[7:0] ^ pm_addr[15:8] ^ 8'h3C;
		end else begin
			pm_rdata <= ~pm_rdata;
		end
	end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the operand address generator.
`timescale 1ns/1ps
`default_nettype none
`include "oag_consts.vh"
module tb_top;
	typedef struct {
		logic [3:0]  m, c;
		logic        fs, ow;
		logic [7:0]  b;
		logic [15:0] w;
		logic        fm, fr;
		logic [1:0]  what, sp;
		logic [15:0] e;
	} row_t;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic req = 1'b0;
	logic [3:0] mode = 4'h0, ins_class = 4'h0;
	logic field_short = 1'b0, op_word = 1'b0;
	logic [7:0] ins_byte = 8'h00, ins_offset = 8'h00, wr_data = 8'h00;
	logic [15:0] ins_word = 16'h0000, pc_follow = 16'h0000;
	logic rp_first_wr = 1'b0, rp_second_wr = 1'b0, sp_low_wr = 1'b0;
	wire [7:0] rf_rdata, pm_rdata, rf_addr;
	wire busy, done, fault_mode, fault_range, pc_load, rf_rd, pm_rd;
	wire [15:0] eff_addr, operand, pc_target, pm_addr;
	wire [1:0] addr_space;
	wire [7:0] first_window_pointer, second_window_pointer, stack_pointer_low;
	int error_cnt = 0;
	int checks = 0;
	row_t rows [29] = '{
		'{`MODE_REG,`INS_GENERIC,0,0,8'h40,0,0,0,1,0,16'h00BF},
		'{`MODE_REG,`INS_GENERIC,0,1,8'h42,0,0,0,1,0,16'hBDBC},
		'{`MODE_WREG,`INS_GENERIC,1,0,8'h05,0,0,0,1,0,16'h003A},
		'{`MODE_WREG,`INS_GENERIC,1,0,8'h0B,0,0,0,1,0,16'h0034},
		'{`MODE_IND,`INS_GENERIC,0,0,8'hA0,0,0,0,0,1,16'h005F},
		'{`MODE_IND,`INS_GENERIC,0,0,8'h20,0,0,1,0,1,16'h00DF},
		'{`MODE_IND,`INS_PM_LOAD,0,0,8'hA2,0,0,0,0,2,16'h5D5C},
		'{`MODE_IND,`INS_JUMP,0,0,8'hA2,0,0,0,2,0,16'h5D5C},
		'{`MODE_IDX_RF,`INS_REG_LOAD,1,0,8'h04,0,0,0,0,1,16'h003F},
		'{`MODE_IDX_RF,`INS_REG_LOAD,1,0,8'h90,0,0,1,0,1,16'h00CF},
		'{`MODE_IDX_RF,`INS_GENERIC,0,0,8'h10,0,1,0,3,0,0},
		'{`MODE_IDX_SHORT,`INS_PM_LOAD,1,0,8'h04,16'h0080,0,0,0,2,16'h3ABA},
		'{`MODE_IDX_SHORT,`INS_EXT_LOAD,1,0,8'h04,16'h007F,0,0,0,3,16'h3BB9},
		'{`MODE_IDX_LONG,`INS_EXT_LOAD,1,0,8'h04,16'h1234,0,0,0,3,16'h4D6E},
		'{`MODE_IDX_SHORT,`INS_REG_LOAD,1,0,8'h04,0,1,0,3,0,0},
		'{`MODE_DIRECT,`INS_JUMP,0,0,0,16'hABCD,0,0,2,0,16'hABCD},
		'{`MODE_DIRECT,`INS_PM_LOAD,0,0,0,16'h1357,0,0,0,2,16'h1357},
		'{`MODE_DIRECT,`INS_GENERIC,0,0,0,16'h1357,1,0,3,0,0},
		'{`MODE_TABLE,`INS_CALL,0,0,8'h40,0,0,0,2,0,16'h7C7D},
		'{`MODE_TABLE,`INS_JUMP,0,0,8'h40,0,1,0,3,0,0},
		'{`MODE_REL,`INS_BTB_FALSE,0,0,8'h80,16'h1000,0,0,2,0,16'h0F80},
		'{`MODE_REL,`INS_BTB_TRUE,0,0,8'h7F,16'h1000,0,0,2,0,16'h107F},
		'{`MODE_REL,`INS_DEC_BNZ,0,0,8'hFE,16'h0001,0,0,2,0,16'hFFFF},
		'{`MODE_REL,`INS_CIB_EQ,0,0,8'h02,16'hFFFF,0,0,2,0,16'h0001},
		'{`MODE_REL,`INS_CIB_NE,0,0,8'h00,16'h2000,0,0,2,0,16'h2000},
		'{`MODE_REL,`INS_SHORT_JR,0,0,8'h10,16'h0100,0,0,2,0,16'h0110},
		'{`MODE_REL,`INS_GENERIC,0,0,8'h10,16'h0100,1,0,3,0,0},
		'{`MODE_LIT,`INS_GENERIC,0,1,8'h5A,16'hBEEF,0,0,1,0,16'hBEEF},
		'{`MODE_LIT,`INS_SHORT_JR,0,0,8'h5A,0,1,0,3,0,0}
	};
	operand_address_generator uut (.*);
	memory_model partner (.*);
	always #12.5 clk_sys = ~clk_sys;
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("Checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic drive(input row_t r);
		@(posedge clk_sys);
		req <= 1'b1;
		mode <= r.m;
		ins_class <= r.c;
		field_short <= r.fs;
		op_word <= r.ow;
		ins_byte <= r.b;
		ins_offset <= r.w[7:0];
		ins_word <= r.w;
		pc_follow <= r.w;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while (done !== 1'b1 && n < 8);
		check("done", 16'(done), 16'h0001);
	endtask
	task automatic run(input row_t r);
		drive(r);
		@(posedge clk_sys);
		req <= 1'b0;
		wait_done();
	endtask
	task automatic write_ptr(input int sel, input logic [7:0] v);
		@(posedge clk_sys);
		rp_first_wr <= (sel == 0);
		rp_second_wr <= (sel == 1);
		sp_low_wr <= (sel == 2);
		wr_data <= v;
		@(posedge clk_sys);
		{rp_first_wr, rp_second_wr, sp_low_wr} <= 3'b000;
	endtask
	task automatic do_reset;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		check("first_ptr", 16'(first_window_pointer), 16'(`RP_FIRST_RESET));
		check("second_ptr", 16'(second_window_pointer), 16'(`RP_SECOND_RESET));
		check("stack_ptr", 16'(stack_pointer_low), 16'(`SP_LOW_RESET));
		check("busy_done", 16'({busy, done}), 16'h0000);
	endtask
	initial begin
		#(25 * 4000);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		do_reset();
		foreach (rows[i]) begin
			run(rows[i]);
			check("fault_mode", 16'(fault_mode), 16'(rows[i].fm));
			check("fault_range", 16'(fault_range), 16'(rows[i].fr));
			if (rows[i].what == 2'd0) begin
				check("eff_addr", eff_addr, rows[i].e);
				check("addr_space", 16'(addr_space), 16'(rows[i].sp));
			end
			if (rows[i].what == 2'd1) begin
				check("operand", operand, rows[i].e);
			end
			if (rows[i].what == 2'd2) begin
				check("pc_target", pc_target, rows[i].e);
			end
			$display("Row %0d finished", i);
		end
		// Moved windows: escaped and short references must follow the new pointers.
		write_ptr(0, 8'h70);
		write_ptr(1, 8'hA8);
		run('{`MODE_REG, `INS_GENERIC, 0, 0, 8'hC6, 0, 0, 0, 1, 0, 0});
		check("operand", operand, 16'h0089);
		run('{`MODE_WREG, `INS_GENERIC, 1, 0, 8'h0B, 0, 0, 0, 1, 0, 0});
		check("operand", operand, 16'h0054);
		$display("Window test finished");
		write_ptr(2, 8'h20);
		run('{`MODE_PUSH, `INS_PUSH, 0, 0, 0, 0, 0, 0, 0, 0, 0});
		run('{`MODE_PUSH, `INS_PUSH, 0, 0, 0, 0, 0, 0, 0, 0, 0});
		check("push_addr", 16'(eff_addr[7:0]), 16'h001E);
		run('{`MODE_POP, `INS_POP, 0, 0, 0, 0, 0, 0, 0, 0, 0});
		check("pop_addr", 16'(eff_addr[7:0]), 16'h001E);
		check("stack_ptr", 16'(stack_pointer_low), 16'h001F);
		$display("Stack test finished");
		// A request held through a busy pair read is ignored, then taken at the edge that sees done high.
		drive('{`MODE_IND, `INS_PM_LOAD, 0, 0, 8'hA2, 0, 0, 0, 0, 0, 0});
		drive('{`MODE_LIT, `INS_GENERIC, 0, 0, 8'h77, 0, 0, 0, 0, 0, 0});
		wait_done();
		check("eff_addr", eff_addr, 16'h5D5C);
		@(posedge clk_sys);
		req <= 1'b0;
		wait_done();
		check("operand", operand, 16'h0077);
		$display("Back to back test finished");
		do_reset();
		$display("Reset test finished");
		report_and_stop();
	end
endmodule
`default_nettype wire
